// *** rtl/ccmc_channel.sv ***
// one capture/compare channel: edge capture, match, toggle, pwm and frequency output
`timescale 1ns/1ps
`include "ccmc_regs.svh"
module ccmc_channel (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration
    input wire logic [7:0] mode,
    input wire logic [1:0] cycle_sel,
    input wire logic [15:0] counter,
    input wire logic [15:0] compare,
    // pin
    input wire logic pin_in,
    output logic pin_out,
    // results
    output logic capture_stb,
    output logic [15:0] capture_val,
    output logic event_stb,
    output ccmc_pkg::ccmc_mode_e mode_now
);
    logic pin_reg, pin_next;
    logic out_reg, out_next;
    logic [15:0] cap_reg, cap_next;
    logic [7:0] freq_cnt_reg, freq_cnt_next;
    logic rise, fall, hit;
    logic [15:0] cycle_mask;
    ccmc_pkg::ccmc_mode_e md;

    // ==========================================================
    // mode decode
    always_comb begin
        md = ccmc_pkg::CCMC_OFF;
        if (mode[`CCMC_B_PWM] && mode[`CCMC_B_TOG]) begin
            md = ccmc_pkg::CCMC_FREQ;
        end else if (mode[`CCMC_B_PWM]) begin
            md = mode[`CCMC_B_WIDE] ? ccmc_pkg::CCMC_PWM16 : ccmc_pkg::CCMC_PWM8;
        end else if (mode[`CCMC_B_TOG]) begin
            md = ccmc_pkg::CCMC_TOGGLE;
        end else if (mode[`CCMC_B_MATCH]) begin
            md = ccmc_pkg::CCMC_MATCH;
        end else if (mode[`CCMC_B_RISE] || mode[`CCMC_B_FALL]) begin
            md = ccmc_pkg::CCMC_CAPTURE;
        end
        // cycle length of the narrow pwm: 8 + select bits
        cycle_mask = 16'h00FF;
        case (cycle_sel)
            2'b01: cycle_mask = 16'h01FF;
            2'b10: cycle_mask = 16'h03FF;
            2'b11: cycle_mask = 16'h07FF;
            default: cycle_mask = 16'h00FF;
        endcase
    end

    assign mode_now = md;
    assign rise = pin_in && !pin_reg && mode[`CCMC_B_RISE];
    assign fall = !pin_in && pin_reg && mode[`CCMC_B_FALL];
    assign hit = mode[`CCMC_B_CMP] && (counter[7:0] == compare[7:0]);
    assign capture_stb = rise || fall;
    assign capture_val = cap_reg;
    assign pin_out = out_reg;
    assign event_stb = capture_stb || (hit && mode[`CCMC_B_MATCH]);

    // ==========================================================
    // next state
    always_comb begin
        pin_next = pin_in;
        cap_next = capture_stb ? counter : cap_reg;
        out_next = out_reg;
        freq_cnt_next = freq_cnt_reg;
        case (md)
            ccmc_pkg::CCMC_TOGGLE: begin
                if (hit) out_next = !out_reg;
            end
            ccmc_pkg::CCMC_PWM8: begin
                out_next = (counter & cycle_mask) >= (compare & cycle_mask);
            end
            ccmc_pkg::CCMC_PWM16: begin
                out_next = counter >= compare;
            end
            ccmc_pkg::CCMC_FREQ: begin
                // ticks every clock: half period is the high compare byte plus one
                if (freq_cnt_reg == 8'h00) begin
                    freq_cnt_next = compare[15:8];
                    out_next = !out_reg;
                end else begin
                    freq_cnt_next = freq_cnt_reg - 8'h01;
                end
            end
            default: out_next = out_reg;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_reg <= 1'b0;
            out_reg <= 1'b0;
            cap_reg <= `CCMC_RST_CNT;
            freq_cnt_reg <= `CCMC_RST_BYTE;
        end else begin
            pin_reg <= pin_next;
            out_reg <= out_next;
            cap_reg <= cap_next;
            freq_cnt_reg <= freq_cnt_next;
        end
    end

    // ==========================================================
    // checks
    a_fall_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (mode[`CCMC_B_FALL] && pin_reg && !pin_in) |=> cap_reg == $past(counter))
        else $error("falling capture value wrong");
    a_rise_capture: assert property (@(posedge clk) disable iff (!rst_n)
        (mode[`CCMC_B_RISE] && !pin_reg && pin_in) |=> cap_reg == $past(counter))
        else $error("rising capture value wrong");
    a_wide_select: assert property (@(posedge clk) disable iff (!rst_n)
        (mode[`CCMC_B_PWM] && !mode[`CCMC_B_TOG] && mode[`CCMC_B_WIDE])
        |=> out_reg == ($past(counter) >= $past(compare)))
        else $error("wide pwm output wrong");
    a_freq_mode: assert property (@(posedge clk) disable iff (!rst_n)
        (md == ccmc_pkg::CCMC_FREQ && freq_cnt_reg == 8'h00) |=> out_reg != $past(out_reg))
        else $error("frequency output did not toggle");
    a_cycle_len: assert property (@(posedge clk) disable iff (!rst_n)
        (md == ccmc_pkg::CCMC_PWM8 && cycle_sel == 2'b10)
        |=> out_reg == ($past(counter[9:0]) >= $past(compare[9:0])))
        else $error("cycle length wrong");
    c_capture: cover property (@(posedge clk) disable iff (!rst_n) capture_stb);
    c_freq: cover property (@(posedge clk) disable iff (!rst_n) md == ccmc_pkg::CCMC_FREQ);
    c_pwm: cover property (@(posedge clk) disable iff (!rst_n) md == ccmc_pkg::CCMC_PWM8 && out_reg);
endmodule

// *** rtl/ccmc_pkg.sv ***
// types of the capture/compare block
package ccmc_pkg;
    typedef enum logic [2:0] {
        CCMC_OFF, CCMC_CAPTURE, CCMC_MATCH, CCMC_TOGGLE, CCMC_PWM8, CCMC_PWM16, CCMC_FREQ
    } ccmc_mode_e;
    typedef logic [7:0] ccmc_byte_t;
endpackage

// *** rtl/ccmc_regs.svh ***
// register offsets, field positions and reset values of the capture/compare block
`ifndef CCMC_REGS_SVH
`define CCMC_REGS_SVH
// ==========================================================
// offsets
`define CCMC_OFF_CNT_LO 8'hF9
`define CCMC_OFF_CNT_HI 8'hFA
`define CCMC_OFF_CLSEL 8'hD9
`define CCMC_OFF_MODE0 8'hDA
`define CCMC_OFF_CPL0 8'hFB
`define CCMC_OFF_CPH0 8'hFC
`define CCMC_OFF_CPL1 8'hE9
`define CCMC_OFF_CPH1 8'hEA
`define CCMC_OFF_CPL2 8'hEB
`define CCMC_OFF_CPH2 8'hEC
// ==========================================================
// mode field positions
`define CCMC_B_WIDE 7
`define CCMC_B_CMP 6
`define CCMC_B_RISE 5
`define CCMC_B_FALL 4
`define CCMC_B_MATCH 3
`define CCMC_B_TOG 2
`define CCMC_B_PWM 1
`define CCMC_B_IRQM 0
// ==========================================================
// reset values
`define CCMC_RST_BYTE 8'h00
`define CCMC_RST_CNT 16'h0000
`endif

// *** rtl/ccmc_top.sv ***
// counter, register file and three capture/compare channels on the special-function bus
`timescale 1ns/1ps
`include "ccmc_regs.svh"
// What this block does
// - falling edge on a channel pin captures the counter when falling enable set
// - pwm uses 16-bit mode when wide select is 1, else 8 to 11 bits
// - pwm plus toggle enable makes the channel a frequency output
// - counter low byte register is counter bits 7:0, reset zero
// - watchdog enable set blocks software writes to the counter low byte
// - reading the low byte snapshots the high byte for later high reads
// - narrow pwm cycle length 8, 9, 10 or 11 bits from 2-bit select
// - writing a channel compare low byte clears its comparator enable
module ccmc_top #(
    parameter int CHANNELS = 3
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // special-function register bus
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    // control
    input wire logic watchdog_enable_bit,
    input wire logic count_enable,
    // channel pins
    input wire logic [2:0] chan_pin_in,
    output logic [2:0] chan_pin_out,
    output logic [2:0] module_event_flag
);
    logic rst_s1, rst_n;
    logic [15:0] cnt_reg, cnt_next;
    logic [7:0] snap_reg, snap_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [1:0] clsel_reg, clsel_next;
    logic [7:0] mode_reg [3], mode_next [3];
    logic [15:0] cmp_reg [3], cmp_next [3];
    logic [15:0] cap_val [3];
    logic [2:0] cap_stb, ev_stb, flag_reg, flag_next;
    logic [2:0] cap_dly_reg, cap_dly_next;
    logic wr_lo;

    // ==========================================================
    // reset release
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    function automatic logic [7:0] cpl_off(input int ch);
        cpl_off = (ch == 0) ? `CCMC_OFF_CPL0 : (ch == 1) ? `CCMC_OFF_CPL1 : `CCMC_OFF_CPL2;
    endfunction
    function automatic logic [7:0] cph_off(input int ch);
        cph_off = (ch == 0) ? `CCMC_OFF_CPH0 : (ch == 1) ? `CCMC_OFF_CPH1 : `CCMC_OFF_CPH2;
    endfunction

    // ==========================================================
    // channels
    for (genvar g = 0; g < 3; g++) begin : g_ch
        ccmc_channel u_ch (
            .clk(clk_sys),
            .rst_n(rst_n),
            .mode(mode_reg[g]),
            .cycle_sel(clsel_reg),
            .counter(cnt_reg),
            .compare(cmp_reg[g]),
            .pin_in(chan_pin_in[g]),
            .pin_out(chan_pin_out[g]),
            .capture_stb(cap_stb[g]),
            .capture_val(cap_val[g]),
            .event_stb(ev_stb[g]),
            .mode_now()
        );
    end

    assign wr_lo = sfr_wr && sfr_addr == `CCMC_OFF_CNT_LO && !watchdog_enable_bit;
    assign sfr_rdata = rdata_reg;
    assign module_event_flag = flag_reg;

    // ==========================================================
    // register file next state
    always_comb begin
        cnt_next = count_enable ? cnt_reg + 16'h0001 : cnt_reg;
        snap_next = snap_reg;
        clsel_next = clsel_reg;
        rdata_next = 8'h00;
        flag_next = flag_reg | ev_stb;
        // channel registers the counter at the edge, so hand it over one cycle later
        cap_dly_next = cap_stb;
        for (int i = 0; i < 3; i++) begin
            mode_next[i] = mode_reg[i];
            cmp_next[i] = cap_dly_reg[i] ? cap_val[i] : cmp_reg[i];
        end
        if (wr_lo) begin
            cnt_next = {cnt_next[15:8], sfr_wdata};
        end else if (sfr_wr && sfr_addr == `CCMC_OFF_CNT_HI && !watchdog_enable_bit) begin
            cnt_next = {sfr_wdata, cnt_next[7:0]};
        end else if (sfr_wr && sfr_addr == `CCMC_OFF_CLSEL) begin
            clsel_next = sfr_wdata[1:0];
        end
        for (int i = 0; i < 3; i++) begin
            if (sfr_wr && sfr_addr == `CCMC_OFF_MODE0 + 8'(i)) begin
                mode_next[i] = sfr_wdata;
            end else if (sfr_wr && sfr_addr == cpl_off(i)) begin
                cmp_next[i] = {cmp_reg[i][15:8], sfr_wdata};
                mode_next[i][`CCMC_B_CMP] = 1'b0;
            end else if (sfr_wr && sfr_addr == cph_off(i)) begin
                cmp_next[i] = {sfr_wdata, cmp_reg[i][7:0]};
                mode_next[i][`CCMC_B_CMP] = 1'b1;
            end
        end
        if (sfr_rd) begin
            if (sfr_addr == `CCMC_OFF_CNT_LO) begin
                rdata_next = cnt_reg[7:0];
                snap_next = cnt_reg[15:8];
            end else if (sfr_addr == `CCMC_OFF_CNT_HI) begin
                rdata_next = snap_reg;
            end else if (sfr_addr == `CCMC_OFF_CLSEL) begin
                rdata_next = {6'h00, clsel_reg};
            end
            for (int i = 0; i < 3; i++) begin
                if (sfr_addr == `CCMC_OFF_MODE0 + 8'(i)) rdata_next = mode_reg[i];
                if (sfr_addr == cpl_off(i)) rdata_next = cmp_reg[i][7:0];
                if (sfr_addr == cph_off(i)) rdata_next = cmp_reg[i][15:8];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= `CCMC_RST_CNT;
            snap_reg <= `CCMC_RST_BYTE;
            rdata_reg <= `CCMC_RST_BYTE;
            clsel_reg <= 2'h0;
            flag_reg <= 3'h0;
            cap_dly_reg <= 3'h0;
            for (int i = 0; i < 3; i++) begin
                mode_reg[i] <= `CCMC_RST_BYTE;
                cmp_reg[i] <= `CCMC_RST_CNT;
            end
        end else begin
            cnt_reg <= cnt_next;
            snap_reg <= snap_next;
            rdata_reg <= rdata_next;
            clsel_reg <= clsel_next;
            flag_reg <= flag_next;
            cap_dly_reg <= cap_dly_next;
            for (int i = 0; i < 3; i++) begin
                mode_reg[i] <= mode_next[i];
                cmp_reg[i] <= cmp_next[i];
            end
        end
    end

    // ==========================================================
    // checks
    a_low_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        wr_lo |=> cnt_reg[7:0] == $past(sfr_wdata))
        else $error("low byte write lost");
    a_low_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_rd && sfr_addr == `CCMC_OFF_CNT_LO) |=> sfr_rdata == $past(cnt_reg[7:0]))
        else $error("low byte read wrong");
    a_wdt_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CNT_LO && watchdog_enable_bit && !count_enable)
        |=> $stable(cnt_reg))
        else $error("write passed while watchdog on");
    a_wdt_high: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CNT_HI && watchdog_enable_bit && !count_enable)
        |=> $stable(cnt_reg))
        else $error("high write passed while watchdog on");
    // a byte write wins over the increment, so only quiet cycles are checked
    a_count_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (count_enable && !sfr_wr) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter did not step");
    a_snap_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_rd && sfr_addr == `CCMC_OFF_CNT_LO) |=> snap_reg == $past(cnt_reg[15:8]))
        else $error("snapshot not taken");
    a_high_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_rd && sfr_addr == `CCMC_OFF_CNT_HI) |=> sfr_rdata == $past(snap_reg))
        else $error("high read not from snapshot");
    a_rdata_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sfr_rd |=> sfr_rdata == 8'h00)
        else $error("read data not cleared");
    a_clsel_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CLSEL) |=> clsel_reg == $past(sfr_wdata[1:0]))
        else $error("cycle select write lost");
    a_mode_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_MODE0) |=> mode_reg[0] == $past(sfr_wdata))
        else $error("mode write lost");
    a_cmp_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CPL0) |=> !mode_reg[0][`CCMC_B_CMP])
        else $error("comparator enable not cleared");
    a_cmp_clear_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CPL1) |=> !mode_reg[1][`CCMC_B_CMP])
        else $error("comparator enable one not cleared");
    a_cmp_clear_two: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CPL2) |=> !mode_reg[2][`CCMC_B_CMP])
        else $error("comparator enable two not cleared");
    a_cmp_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CPH0) |=> mode_reg[0][`CCMC_B_CMP])
        else $error("comparator enable not set");
    a_cmp_set_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_wr && sfr_addr == `CCMC_OFF_CPH1) |=> mode_reg[1][`CCMC_B_CMP])
        else $error("comparator enable one not set");
    a_capture_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (cap_stb[0] ##1 !sfr_wr) |=> cmp_reg[0] == $past(cnt_reg, 2))
        else $error("captured counter not stored");
    // flags have no clear path, so once set they stay set
    a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flag_reg[0] |=> flag_reg[0])
        else $error("event flag dropped");
    c_snap: cover property (@(posedge clk_sys) disable iff (!rst_n)
        (sfr_rd && sfr_addr == `CCMC_OFF_CNT_LO) ##1 (sfr_rd && sfr_addr == `CCMC_OFF_CNT_HI));
    c_block: cover property (@(posedge clk_sys) disable iff (!rst_n)
        sfr_wr && sfr_addr == `CCMC_OFF_CNT_LO && watchdog_enable_bit);
endmodule

// *** verif/tb_ccmc_top.sv ***
// self-checking bench for the capture/compare block
`timescale 1ns/1ps
`include "ccmc_regs.svh"
module tb_ccmc_top;
    logic clk_sys;
    logic rst_b;
    logic [7:0] sfr_addr;
    logic sfr_wr;
    logic sfr_rd;
    logic [7:0] sfr_wdata;
    logic [7:0] sfr_rdata;
    logic watchdog_enable_bit;
    logic count_enable;
    logic [2:0] chan_pin_in;
    logic [2:0] chan_pin_out;
    logic [2:0] module_event_flag;
    logic [7:0] d;
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    ccmc_top #(.CHANNELS(3)) uut (
        .clk_sys(clk_sys), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .watchdog_enable_bit(watchdog_enable_bit), .count_enable(count_enable),
        .chan_pin_in(chan_pin_in), .chan_pin_out(chan_pin_out),
        .module_event_flag(module_event_flag)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ==========================================================
    // reporting and bus access
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("wrong value at %0t: run hung", $time);
            end_of_test();
        end
    end

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_wdata = v;
        sfr_wr = 1'b1;
        @(negedge clk_sys);
        sfr_wr = 1'b0;
    endtask

    // data is registered at the read edge, so it is settled at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(negedge clk_sys);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge clk_sys);
        sfr_rd = 1'b0;
        v = sfr_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
        logic [7:0] v;
        rd(a, v);
        chk8(v, exp, what);
    endtask

    task automatic set_cnt(input logic [15:0] v);
        wr(`CCMC_OFF_CNT_HI, v[15:8]);
        wr(`CCMC_OFF_CNT_LO, v[7:0]);
    endtask

    task automatic settle();
        repeat (4) @(negedge clk_sys);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_counter();
        rd_chk(`CCMC_OFF_CNT_LO, 8'h00, "counter low reset");
        rd_chk(`CCMC_OFF_MODE0, 8'h00, "mode reset");
        rd_chk(8'h00, 8'h00, "unmapped read");
        wr(8'hDB, 8'hA5);
        rd_chk(8'hDB, 8'hA5, "mode read back");
        set_cnt(16'h12AB);
        watchdog_enable_bit = 1'b1;
        wr(`CCMC_OFF_CNT_LO, 8'h55);
        rd_chk(`CCMC_OFF_CNT_LO, 8'hAB, "low write blocked");
        watchdog_enable_bit = 1'b0;
        wr(`CCMC_OFF_CNT_HI, 8'h34);
        rd_chk(`CCMC_OFF_CNT_HI, 8'h12, "stale snapshot");
        rd_chk(`CCMC_OFF_CNT_LO, 8'hAB, "low after high write");
        rd_chk(`CCMC_OFF_CNT_HI, 8'h34, "fresh snapshot");
    endtask

    // channel 2 toggles and flags on a low-byte match of the running counter
    task automatic t_toggle();
        set_cnt(16'h001F);
        wr(`CCMC_OFF_CPL2, 8'h20);
        wr(`CCMC_OFF_CPH2, 8'h00);
        wr(8'hDC, 8'h4C);
        chk1(chan_pin_out[2], 1'b0, "toggle before match");
        chk1(module_event_flag[2], 1'b0, "flag before match");
        count_enable = 1'b1;
        repeat (2) @(negedge clk_sys);
        count_enable = 1'b0;
        settle();
        chk1(chan_pin_out[2], 1'b1, "toggle on match");
        chk1(module_event_flag[2], 1'b1, "flag on match");
    endtask

    task automatic t_capture();
        set_cnt(16'h1357);
        wr(`CCMC_OFF_MODE0, 8'h20);
        chan_pin_in[0] = 1'b1;
        settle();
        rd_chk(`CCMC_OFF_CPL0, 8'h57, "rise capture low");
        rd_chk(`CCMC_OFF_CPH0, 8'h13, "rise capture high");
        chk1(module_event_flag[0], 1'b1, "rise flag");
        set_cnt(16'h2468);
        wr(8'hDB, 8'h10);
        chan_pin_in[1] = 1'b1;
        settle();
        rd_chk(`CCMC_OFF_CPL1, 8'h00, "no capture on rise");
        chk1(module_event_flag[1], 1'b0, "no flag on rise");
        chan_pin_in[1] = 1'b0;
        settle();
        rd_chk(`CCMC_OFF_CPL1, 8'h68, "fall capture low");
        rd_chk(`CCMC_OFF_CPH1, 8'h24, "fall capture high");
        chk1(module_event_flag[1], 1'b1, "fall flag");
        wr(8'hDC, 8'h30);
        set_cnt(16'h0A0B);
        chan_pin_in[2] = 1'b1;
        settle();
        rd_chk(`CCMC_OFF_CPL2, 8'h0B, "both edges rise");
        set_cnt(16'h0C0D);
        chan_pin_in[2] = 1'b0;
        settle();
        rd_chk(`CCMC_OFF_CPL2, 8'h0D, "both edges fall low");
        rd_chk(`CCMC_OFF_CPH2, 8'h0C, "both edges fall high");
    endtask

    task automatic t_cmp_enable();
        wr(`CCMC_OFF_CPH1, 8'h00);
        rd(8'hDB, d);
        chk1(d[6], 1'b1, "high write sets enable");
        wr(`CCMC_OFF_CPL1, 8'h00);
        rd(8'hDB, d);
        chk1(d[6], 1'b0, "low write clears enable");
    endtask

    // counter 0x0080 against compare 1<<b: high only while bit b is cut off by the cycle length
    task automatic t_pwm();
        logic [15:0] c;
        set_cnt(16'h0080);
        for (int s = 0; s < 4; s++) begin
            wr(`CCMC_OFF_CLSEL, 8'(s));
            for (int b = 8; b < 12; b++) begin
                c = 16'h0001 << b;
                wr(`CCMC_OFF_CPL0, c[7:0]);
                wr(`CCMC_OFF_CPH0, c[15:8]);
                wr(`CCMC_OFF_MODE0, 8'h42);
                settle();
                chk1(chan_pin_out[0], logic'(b >= 8 + s), "narrow pwm level");
            end
        end
        wr(`CCMC_OFF_MODE0, 8'hC2);
        settle();
        chk1(chan_pin_out[0], 1'b0, "wide pwm ignores cycle length");
    endtask

    task automatic t_freq();
        logic last;
        wr(`CCMC_OFF_CPL2, 8'h00);
        wr(`CCMC_OFF_CPH2, 8'h03);
        wr(8'hDC, 8'h46);
        count_enable = 1'b1;
        last = chan_pin_out[2];
        n = 0;
        while (chan_pin_out[2] === last && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        last = chan_pin_out[2];
        n = 0;
        while (chan_pin_out[2] === last && n < 40) begin
            @(negedge clk_sys);
            n++;
        end
        chk8(8'(n), 8'h04, "frequency half period");
        count_enable = 1'b0;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
        watchdog_enable_bit = 1'b0;
        count_enable = 1'b0;
        chan_pin_in = 3'h0;
        repeat (20) @(negedge clk_sys);
        rst_b = 1'b1;
        settle();
        t_counter();
        t_toggle();
        t_capture();
        t_cmp_enable();
        t_pwm();
        t_freq();
        end_of_test();
    end
endmodule
